// ===== design/gpio_d_pkg.sv
// Constants for the eight-bit port D block with parallel slave takeover.
// Assumes a plain register port and one 40 MHz core clock.
package gpio_d_pkg;
  localparam int          PORT_W         = 8;
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  ADDR_PINS      = 4'h0;
  localparam logic [3:0]  ADDR_LATCH     = 4'h1;
  localparam logic [3:0]  ADDR_DIR       = 4'h2;
  localparam logic [3:0]  ADDR_PE_DIR    = 4'h3;
  localparam logic [3:0]  ADDR_PWM_MODE  = 4'h4;
  localparam logic [7:0]  RST_LATCH      = 8'h00;
  localparam logic [7:0]  RST_DIR        = 8'hff;
  localparam logic [7:0]  RST_PE_DIR     = 8'h07;
  localparam logic [7:0]  RST_IO         = 8'h00;
  localparam logic [7:0]  PE_DIR_WMASK   = 8'h17;
  localparam int          PSP_EN_BIT     = 4;
  localparam int          PWM_B_BIT      = 5;
  localparam int          PWM_C_BIT      = 6;
  localparam int          PWM_D_BIT      = 7;
  localparam logic [1:0]  PWM_SINGLE     = 2'h0;
  localparam logic [1:0]  RST_PWM_MODE   = 2'h0;
  typedef enum logic [2:0] {
    PS_IDLE  = 3'b001,
    PS_READ  = 3'b010,
    PS_WRITE = 3'b100
  } slave_state_t;
endpackage : gpio_d_pkg

// ===== design/gpio_d_if.sv
// Carries steering signals from the top to the mux leaf and pin results back.
// Assumes one driver per signal: the leaf drives outputs of its modport.
`timescale 1ns/1ps
`default_nettype none
interface gpio_d_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic       slave_read;
  logic       slave_write;
  logic [2:0] pwm_en;
  logic [2:0] pwm_val;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  modport core (output latch, dir, slave_read, slave_write, pwm_en,
                pwm_val, input pin_out, pin_oe);
  modport mux  (input latch, dir, slave_read, slave_write, pwm_en,
                pwm_val, output pin_out, pin_oe);
endinterface : gpio_d_if
`default_nettype wire

// ===== design/gpio_d_mux.sv
// Combinational per-pin source and direction selection.
// Assumes the top registers its outputs after this mux.
`timescale 1ns/1ps
`default_nettype none
module gpio_d_mux (
  gpio_d_if.mux m
);
  wire [7:0] pwm_en8  = {m.pwm_en, 5'h00};
  wire [7:0] pwm_val8 = {m.pwm_val, 5'h00};
  wire [7:0] port_oe  = ~m.dir;
  wire [7:0] slave_oe = m.slave_write ? 8'h00 :
                        (m.slave_read ? 8'hff : port_oe);
  // PWM wins over both port and slave data
  assign m.pin_oe  = slave_oe | pwm_en8;
  assign m.pin_out = (pwm_en8 & pwm_val8) | (~pwm_en8 & m.latch);
endmodule : gpio_d_mux
`default_nettype wire

// ===== design/gpio_d_port.sv
// Port D top: registers, slave takeover and PWM override of the pins.
// Assumes synchronous pin inputs and strobes, one clock, async reset.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Eight pins, each with its own direction
// - Direction one disables the pin driver
// - Direction zero drives latch bit out
// - Latch register reads back latched values
// - Reset makes every pin an input
// - Slave enable turns port into slave bus
// - Dual or quad PWM disables slave
// - Slave read drives latch regardless direction
// - Slave write makes all non-PWM pins inputs
// - Three pins carry PWM channels B-D
// - PWM on bits 5-7 overrides all
// - Port E direction bit 4 holds slave control
module gpio_d_port (
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [7:0] PIN_IN,
  output logic      [7:0] PIN_OUT,
  output logic      [7:0] PIN_OE,
  input  wire logic       SLAVE_RD_N,
  input  wire logic       SLAVE_WR_N,
  input  wire logic       SLAVE_CS_N,
  input  wire logic [2:0] PWM_EN,
  input  wire logic [2:0] PWM_VAL,
  output logic            SLAVE_ACTIVE
);
  logic [7:0] latch_ff;
  logic [7:0] dir_ff;
  logic [7:0] pe_dir_ff;
  logic [1:0] pwm_mode_ff;
  logic [7:0] pins_ff;
  gpio_d_pkg::slave_state_t state_ff;
  gpio_d_pkg::slave_state_t nxt_state;
  gpio_d_if pif ();

  // One address compare shared by write decode and read select
  function automatic logic addr_hit(input logic [3:0] a,
                                    input logic [3:0] want);
    return a == want;
  endfunction : addr_hit

  wire sel_pins  = addr_hit(ADDR, gpio_d_pkg::ADDR_PINS);
  wire sel_latch = addr_hit(ADDR, gpio_d_pkg::ADDR_LATCH);
  wire sel_dir   = addr_hit(ADDR, gpio_d_pkg::ADDR_DIR);
  wire sel_pe    = addr_hit(ADDR, gpio_d_pkg::ADDR_PE_DIR);
  wire sel_mode  = addr_hit(ADDR, gpio_d_pkg::ADDR_PWM_MODE);

  wire wr_pins  = WR && sel_pins;
  wire wr_latch = WR && sel_latch;
  wire wr_dir   = WR && sel_dir;
  wire wr_pe    = WR && sel_pe;
  wire wr_mode  = WR && sel_mode;

  // Multi-output PWM steals the slave port outright
  wire pwm_multi  = (pwm_mode_ff != gpio_d_pkg::PWM_SINGLE);
  wire slave_on   = pe_dir_ff[gpio_d_pkg::PSP_EN_BIT] && !pwm_multi;
  wire slave_sel  = slave_on && !SLAVE_CS_N;
  wire slave_rd   = slave_sel && !SLAVE_RD_N;
  wire slave_wr   = slave_sel && !SLAVE_WR_N && SLAVE_RD_N;

  always_comb begin
    unique case (state_ff)
      gpio_d_pkg::PS_IDLE:  nxt_state = slave_rd ? gpio_d_pkg::PS_READ :
                            (slave_wr ? gpio_d_pkg::PS_WRITE :
                             gpio_d_pkg::PS_IDLE);
      gpio_d_pkg::PS_READ:  nxt_state = slave_rd ? gpio_d_pkg::PS_READ :
                                        gpio_d_pkg::PS_IDLE;
      gpio_d_pkg::PS_WRITE: nxt_state = slave_wr ? gpio_d_pkg::PS_WRITE :
                                        gpio_d_pkg::PS_IDLE;
      default:              nxt_state = gpio_d_pkg::PS_IDLE;
    endcase
  end

  assign pif.latch       = latch_ff;
  assign pif.dir         = dir_ff;
  assign pif.slave_read  = (state_ff == gpio_d_pkg::PS_READ);
  assign pif.slave_write = (state_ff == gpio_d_pkg::PS_WRITE);
  assign pif.pwm_en      = PWM_EN;
  assign pif.pwm_val     = PWM_VAL;

  gpio_d_mux u_mux (
    .m (pif.mux)
  );

  // Slave write data lands in the pin sample like an ordinary input
  wire [7:0] rd_mux =
    sel_pins  ? pins_ff :
    sel_latch ? latch_ff :
    sel_dir   ? dir_ff :
    sel_pe    ? pe_dir_ff :
    sel_mode  ? {6'h00, pwm_mode_ff} : 8'h00;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      latch_ff    <= gpio_d_pkg::RST_LATCH;
      dir_ff      <= gpio_d_pkg::RST_DIR;
      pe_dir_ff   <= gpio_d_pkg::RST_PE_DIR;
      pwm_mode_ff <= gpio_d_pkg::RST_PWM_MODE;
    end else begin
      if (wr_pins || wr_latch) latch_ff <= WDATA;
      if (wr_dir) dir_ff <= WDATA;
      if (wr_pe) pe_dir_ff <= WDATA & gpio_d_pkg::PE_DIR_WMASK;
      if (wr_mode) pwm_mode_ff <= WDATA[1:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff     <= gpio_d_pkg::PS_IDLE;
      pins_ff      <= gpio_d_pkg::RST_IO;
      RDATA        <= gpio_d_pkg::RST_IO;
      PIN_OUT      <= gpio_d_pkg::RST_IO;
      PIN_OE       <= gpio_d_pkg::RST_IO;
      SLAVE_ACTIVE <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      pins_ff      <= PIN_IN;
      RDATA        <= RD ? rd_mux : 8'h00;
      PIN_OUT      <= pif.pin_out;
      PIN_OE       <= pif.pin_oe;
      SLAVE_ACTIVE <= slave_on;
    end
  end

  property p_dir_in;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (PWM_EN == 3'h0 && state_ff == gpio_d_pkg::PS_IDLE) |=>
        (PIN_OE == ~$past(dir_ff));
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("oe not ~dir");

  property p_drive_latch;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (PWM_EN == 3'h0) |=> (PIN_OUT == $past(latch_ff));
  endproperty
  a_drive_latch: assert property (p_drive_latch) else $error("out");

  property p_latch_read;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (RD && ADDR == gpio_d_pkg::ADDR_LATCH) |=> (RDATA == $past(latch_ff));
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch rd");

  property p_pin_rw;
    @(posedge REF_CLK) disable iff (SYS_RST)
      wr_pins |=> (latch_ff == $past(WDATA));
  endproperty
  a_pin_rw: assert property (p_pin_rw) else $error("pin write");

  property p_multi_off;
    @(posedge REF_CLK) disable iff (SYS_RST)
      pwm_multi |=> !SLAVE_ACTIVE;
  endproperty
  a_multi_off: assert property (p_multi_off) else $error("slave on");

  sequence s_slave_rd;
    state_ff == gpio_d_pkg::PS_READ && PWM_EN == 3'h0;
  endsequence
  property p_slave_rd;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_slave_rd |=> (PIN_OE == 8'hff);
  endproperty
  a_slave_rd: assert property (p_slave_rd) else $error("slave rd");

  property p_slave_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (state_ff == gpio_d_pkg::PS_WRITE && PWM_EN == 3'h0) |=>
        (PIN_OE == 8'h00);
  endproperty
  a_slave_wr: assert property (p_slave_wr) else $error("slave wr");

  property p_pwm;
    @(posedge REF_CLK) disable iff (SYS_RST)
      PWM_EN[0] |=> (PIN_OE[5] && PIN_OUT[5] == $past(PWM_VAL[0]));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm b");

  property p_reset_dir;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(SYS_RST) |->
        (dir_ff == gpio_d_pkg::RST_DIR && PIN_OE == gpio_d_pkg::RST_IO);
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("rst");

  property p_reset_slv;
    @(posedge REF_CLK) disable iff (SYS_RST)
      $fell(SYS_RST) |->
        (!SLAVE_ACTIVE && state_ff == gpio_d_pkg::PS_IDLE);
  endproperty
  a_reset_slv: assert property (p_reset_slv) else $error("rst");

  property p_dir_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      wr_dir |=>
        (dir_ff == $past(WDATA));
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("dir wr");

  property p_latch_wr;
    @(posedge REF_CLK) disable iff (SYS_RST)
      wr_latch |=>
        (latch_ff == $past(WDATA));
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("lat wr");

  property p_dir_rd;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (RD && sel_dir) |=>
        (RDATA == $past(dir_ff));
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("dir rd");

  property p_pins_rd;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (RD && sel_pins) |=>
        (RDATA == $past(pins_ff));
  endproperty
  a_pins_rd: assert property (p_pins_rd) else $error("pin rd");

  property p_pe_rd;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (RD && sel_pe) |=>
        (RDATA == $past(pe_dir_ff));
  endproperty
  a_pe_rd: assert property (p_pe_rd) else $error("pe rd");

  property p_rd_idle;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !RD |=>
        (RDATA == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata");

  property p_pe_en;
    @(posedge REF_CLK) disable iff (SYS_RST)
      wr_pe |=>
        (pe_dir_ff[7:5] == 3'h0 && pe_dir_ff[gpio_d_pkg::PSP_EN_BIT] ==
         $past(WDATA[gpio_d_pkg::PSP_EN_BIT]));
  endproperty
  a_pe_en: assert property (p_pe_en) else $error("pe en");

  property p_slv_on;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (pe_dir_ff[gpio_d_pkg::PSP_EN_BIT] &&
       pwm_mode_ff == gpio_d_pkg::PWM_SINGLE) |=>
        SLAVE_ACTIVE;
  endproperty
  a_slv_on: assert property (p_slv_on) else $error("slv on");

  property p_slv_gate;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (!pe_dir_ff[gpio_d_pkg::PSP_EN_BIT] &&
       state_ff == gpio_d_pkg::PS_IDLE) |=>
        (state_ff == gpio_d_pkg::PS_IDLE && !SLAVE_ACTIVE);
  endproperty
  a_slv_gate: assert property (p_slv_gate) else $error("gate");

  property p_multi_idle;
    @(posedge REF_CLK) disable iff (SYS_RST)
      pwm_multi |=>
        (state_ff == gpio_d_pkg::PS_IDLE);
  endproperty
  a_multi_idle: assert property (p_multi_idle) else $error("multi");

  sequence s_rd_start;
    slave_rd && state_ff == gpio_d_pkg::PS_IDLE;
  endsequence

  sequence s_wr_start;
    slave_wr && state_ff == gpio_d_pkg::PS_IDLE;
  endsequence

  property p_rd_enter;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_rd_start |=>
        (state_ff == gpio_d_pkg::PS_READ);
  endproperty
  a_rd_enter: assert property (p_rd_enter) else $error("rd st");

  property p_rd_walk;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_rd_start |=> ##1
        (PIN_OE[4:0] == 5'h1f &&
         PIN_OUT[4:0] == $past(latch_ff[4:0]));
  endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("rd pin");

  property p_wr_enter;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_wr_start |=>
        (state_ff == gpio_d_pkg::PS_WRITE);
  endproperty
  a_wr_enter: assert property (p_wr_enter) else $error("wr st");

  property p_wr_walk;
    @(posedge REF_CLK) disable iff (SYS_RST)
      s_wr_start |=> ##1
        (PIN_OE[4:0] == 5'h00);
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("wr pin");

  property p_pwm_c;
    @(posedge REF_CLK) disable iff (SYS_RST)
      PWM_EN[1] |=>
        (PIN_OE[gpio_d_pkg::PWM_C_BIT] &&
         PIN_OUT[gpio_d_pkg::PWM_C_BIT] == $past(PWM_VAL[1]));
  endproperty
  a_pwm_c: assert property (p_pwm_c) else $error("pwm c");

  property p_pwm_d;
    @(posedge REF_CLK) disable iff (SYS_RST)
      PWM_EN[2] |=>
        (PIN_OE[gpio_d_pkg::PWM_D_BIT] &&
         PIN_OUT[gpio_d_pkg::PWM_D_BIT] == $past(PWM_VAL[2]));
  endproperty
  a_pwm_d: assert property (p_pwm_d) else $error("pwm d");

  property p_pwm_dir;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (PWM_EN[2] && dir_ff[gpio_d_pkg::PWM_D_BIT]) |=>
        PIN_OE[gpio_d_pkg::PWM_D_BIT];
  endproperty
  a_pwm_dir: assert property (p_pwm_dir) else $error("pwm dir");

  property p_pwm_over;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (PWM_EN[0] && state_ff == gpio_d_pkg::PS_WRITE) |=>
        (PIN_OE[gpio_d_pkg::PWM_B_BIT] &&
         PIN_OUT[gpio_d_pkg::PWM_B_BIT] == $past(PWM_VAL[0]));
  endproperty
  a_pwm_over: assert property (p_pwm_over) else $error("pwm wr");

  property p_pin_off;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (dir_ff[0] && state_ff != gpio_d_pkg::PS_READ) |=>
        !PIN_OE[0];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin off");

  property p_pin_on;
    @(posedge REF_CLK) disable iff (SYS_RST)
      (!dir_ff[0] && state_ff == gpio_d_pkg::PS_IDLE) |=>
        (PIN_OE[0] &&
         PIN_OUT[0] == $past(latch_ff[0]));
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin on");
endmodule : gpio_d_port
`default_nettype wire

// ===== dv/pin_world.sv
// Board-side model that resolves each port pin from device and board.
// Assumes the board drives every pin that the device leaves released.
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  input  wire logic [7:0] drv,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] board,
  output logic      [7:0] lvl
);
  // A released pin shows the board value, never a stale device level
  assign lvl = (drv & oe) | (board & ~oe);
endmodule : pin_world
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for port D: registers, pins, slave and PWM.
// Assumes pin_world resolves the pins; bench drives strobes and PWM.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] board = 8'h3c;
  logic       srd_n = 1'b1;
  logic       swr_n = 1'b1;
  logic       scs_n = 1'b1;
  logic [2:0] pwm_en = 3'h0;
  logic [2:0] pwm_val = 3'h0;
  logic       active;
  int         err_total = 0;
  int         n_compared = 0;
  int         cycles = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  gpio_d_port dut (.REF_CLK(clk), .SYS_RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .SLAVE_RD_N(srd_n),
    .SLAVE_WR_N(swr_n), .SLAVE_CS_N(scs_n), .PWM_EN(pwm_en),
    .PWM_VAL(pwm_val), .SLAVE_ACTIVE(active));
  pin_world board_side (.drv(pin_out), .oe(pin_oe), .board(board),
    .lvl(pin_in));
  task automatic complete_run;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg
  // Only driven bits are compared: a released pin value means nothing
  task automatic pins(input logic [7:0] oe, input logic [7:0] val);
    repeat (3) @(posedge clk);
    #1;
    chk(pin_oe, oe);
    chk(pin_out & pin_oe, val);
  endtask : pins
  task automatic slave(input logic c, input logic r, input logic w);
    @(posedge clk);
    scs_n <= c;
    srd_n <= r;
    swr_n <= w;
  endtask : slave
  task automatic pwm(input logic [2:0] e, input logic [2:0] v);
    @(posedge clk);
    pwm_en <= e;
    pwm_val <= v;
  endtask : pwm
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(pin_oe, 8'h00);
    rd_reg(gpio_d_pkg::ADDR_DIR, 8'hff);
    rd_reg(gpio_d_pkg::ADDR_LATCH, 8'h00);
    rd_reg(gpio_d_pkg::ADDR_PE_DIR, 8'h07);
    wr_reg(gpio_d_pkg::ADDR_PINS, 8'ha5);
    wr_reg(gpio_d_pkg::ADDR_DIR, 8'h0f);
    pins(8'hf0, 8'ha0);
    rd_reg(gpio_d_pkg::ADDR_PINS, 8'hac);
    rd_reg(gpio_d_pkg::ADDR_LATCH, 8'ha5);
    rd_reg(4'hf, 8'h00);
    wr_reg(gpio_d_pkg::ADDR_PE_DIR, 8'hff);
    rd_reg(gpio_d_pkg::ADDR_PE_DIR, 8'h17);
    wr_reg(gpio_d_pkg::ADDR_PE_DIR, 8'h10);
    slave(1'b0, 1'b0, 1'b1);
    pins(8'hff, 8'ha5);
    chk({7'h00, active}, 8'h01);
    pwm(3'h7, 3'h2);
    pins(8'hff, 8'h45);
    slave(1'b0, 1'b1, 1'b0);
    pins(8'he0, 8'h40);
    pwm(3'h0, 3'h0);
    pins(8'h00, 8'h00);
    rd_reg(gpio_d_pkg::ADDR_PINS, 8'h3c);
    wr_reg(gpio_d_pkg::ADDR_PWM_MODE, 8'h01);
    slave(1'b0, 1'b0, 1'b1);
    pins(8'hf0, 8'ha0);
    chk({7'h00, active}, 8'h00);
    wr_reg(gpio_d_pkg::ADDR_DIR, 8'hff);
    pwm(3'h7, 3'h5);
    pins(8'he0, 8'ha0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
